// ### pkg/flash_ctrl_pkg.sv
// Types shared by the flash controller and its strobe cycle generator.
package flash_ctrl_pkg;

	typedef enum logic [3:0] {
		OP_READ_ARRAY  = 4'h0,
		OP_READ_STATUS = 4'h1,
		OP_CLEAR       = 4'h2,
		OP_PROGRAM     = 4'h3,
		OP_LOAD        = 4'h4,
		OP_CHIP_ERASE  = 4'h5,
		OP_SECT_ERASE  = 4'h6,
		OP_SLEEP       = 4'h7,
		OP_ABORT       = 4'h8,
		OP_SUSPEND     = 4'h9,
		OP_RESUME      = 4'ha,
		OP_POLL        = 4'hb
	} op_t;

	typedef struct packed {
		logic        wr;
		logic [19:0] addr;
		logic [7:0]  data;
	} bus_req_t;

	typedef struct packed {
		logic        ce_n;
		logic        we_n;
		logic        oe_n;
		logic [19:0] addr;
		logic [7:0]  dq_out;
		logic        dq_oe;
	} flash_pins_t;

endpackage

// ### pkg/flash_ctrl_regs.svh
// Register offsets, status fields, command codes and timing counts of the flash controller.
`ifndef FLASH_CTRL_REGS_SVH
`define FLASH_CTRL_REGS_SVH

// --------------------
// Clock and strobe timing
// --------------------
`define CLK_MHZ          100
`define T_SETUP_NS       20
`define T_PULSE_NS       50
`define T_RECOVER_NS     30
`define SETUP_CYC        ((`T_SETUP_NS * `CLK_MHZ + 999) / 1000)
`define PULSE_CYC        ((`T_PULSE_NS * `CLK_MHZ + 999) / 1000)
`define RECOVER_CYC      ((`T_RECOVER_NS * `CLK_MHZ + 999) / 1000)

// --------------------
// Software register byte offsets
// --------------------
`define OFS_CMD          8'h00
`define OFS_ADDR         8'h04
`define OFS_WDATA        8'h08
`define OFS_RDATA        8'h0c
`define OFS_STATUS       8'h10

// --------------------
// Controller status word fields
// --------------------
`define ST_BUSY          8
`define ST_REFUSED       9
`define ST_SUSPENDED     10
`define ST_LOCKOUT       11
`define ST_FAILED        12

// --------------------
// Flash status byte fields
// --------------------
`define READY_BIT        7
`define SUSPEND_BIT      6
`define ERASE_FAIL_BIT   5
`define PROGRAM_FAIL_BIT 4
`define RESERVED_MASK    8'hfc

// --------------------
// Flash command codes and unlock cycles
// --------------------
`define CODE_READ_ARRAY  8'hff
`define CODE_READ_STATUS 8'h70
`define CODE_CLEAR       8'h50
`define CODE_PROGRAM     8'ha0
`define CODE_ERASE_SETUP 8'h80
`define CODE_CHIP_ERASE  8'h10
`define CODE_SECT_ERASE  8'h30
`define CODE_SLEEP       8'hc0
`define CODE_ABORT       8'he0
`define CODE_SUSPEND     8'hb0
`define CODE_RESUME      8'hd0
`define UNLOCK1_ADDR     20'h05555
`define UNLOCK1_DATA     8'haa
`define UNLOCK2_ADDR     20'h02aaa
`define UNLOCK2_DATA     8'h55

`endif

// ### rtl/flash_bus_cycle.sv
// One asynchronous strobe read or write cycle on the flash pins.
`timescale 1ns/100ps
`include "flash_ctrl_regs.svh"

module flash_bus_cycle #(
	parameter int SETUP_CYC   = `SETUP_CYC,
	parameter int PULSE_CYC   = `PULSE_CYC,
	parameter int RECOVER_CYC = `RECOVER_CYC
) (
	input  wire logic                   ref_clk,
	input  wire logic                   rst,
	input  wire logic                   start,
	input  flash_ctrl_pkg::bus_req_t    req,
	input  wire logic [7:0]             dq_in,
	output flash_ctrl_pkg::flash_pins_t pins,
	output logic                        done,
	output logic [7:0]                  rdata
);
	import flash_ctrl_pkg::*;

	typedef enum logic [1:0] {
		C_IDLE    = 2'b00,
		C_SETUP   = 2'b01,
		C_STROBE  = 2'b11,
		C_RECOVER = 2'b10
	} cyc_state_t;

	cyc_state_t state_reg;
	logic [7:0] cnt_reg;
	logic       wr_reg;

	// Refuse counts the eight bit phase counter cannot hold.
	initial begin
		if (SETUP_CYC < 1 || SETUP_CYC > 255 || PULSE_CYC < 1 || PULSE_CYC > 255 ||
		    RECOVER_CYC < 1 || RECOVER_CYC > 255)
			$error("flash_bus_cycle: phase counts must lie in 1..255");
	end

	// Chip enable, address and data settle first; the strobe follows, then a recovery phase ends the cycle.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_reg   <= C_IDLE;
			cnt_reg     <= 8'h00;
			wr_reg      <= 1'b0;
			done        <= 1'b0;
			rdata       <= 8'h00;
			pins.ce_n   <= 1'b1;
			pins.we_n   <= 1'b1;
			pins.oe_n   <= 1'b1;
			pins.addr   <= 20'h00000;
			pins.dq_out <= 8'h00;
			pins.dq_oe  <= 1'b0;
		end else begin
			done <= 1'b0;
			unique case (state_reg)
				C_IDLE: begin
					if (start) begin
						wr_reg      <= req.wr;
						pins.ce_n   <= 1'b0;
						pins.addr   <= req.addr;
						pins.dq_out <= req.data;
						pins.dq_oe  <= req.wr;
						cnt_reg     <= 8'(SETUP_CYC - 1);
						state_reg   <= C_SETUP;
					end
				end
				C_SETUP: begin
					if (cnt_reg == 8'h00) begin
						pins.we_n <= ~wr_reg;
						pins.oe_n <= wr_reg;
						cnt_reg   <= 8'(PULSE_CYC - 1);
						state_reg <= C_STROBE;
					end else begin
						cnt_reg <= cnt_reg - 8'h01;
					end
				end
				C_STROBE: begin
					// Output enable rises at the end of every read, so each status
					// read is a fresh falling edge on the device side.
					if (cnt_reg == 8'h00) begin
						pins.we_n <= 1'b1;
						pins.oe_n <= 1'b1; // R05
						if (!wr_reg)
							rdata <= dq_in;
						cnt_reg   <= 8'(RECOVER_CYC - 1);
						state_reg <= C_RECOVER;
					end else begin
						cnt_reg <= cnt_reg - 8'h01;
					end
				end
				C_RECOVER: begin
					if (cnt_reg == 8'h00) begin
						pins.ce_n  <= 1'b1;
						pins.dq_oe <= 1'b0;
						done       <= 1'b1;
						state_reg  <= C_IDLE;
					end else begin
						cnt_reg <= cnt_reg - 8'h01;
					end
				end
			endcase
		end
	end

endmodule

// ### rtl/flash_host_ctrl.sv
// Host controller that sends command sequences to a parallel flash and polls its status.
//
// Behaviour
// R01 - The device keeps answering status reads until another valid command arrives.
// R02 - Host writes read-array to leave status output and read memory again.
// R03 - Status reads carry bits two to seven; data bits zero and one read zero.
// R04 - The device latches status at the later falling edge of enable or output enable.
// R05 - Host toggles output enable between successive status reads while polling.
// R06 - The write state machine never clears the two fail bits.
// R07 - A set fail bit stays set until clear-status is received.
// R08 - Program, erase and read-status writes switch device reads to status.
// R09 - Power-up and wake-up leave status bits seven to four at 1000.
// R10 - Bit three shows sector protection only and no command changes it.
// R11 - Bit two is one in sleep or abort; only read-array resets it.
// R12 - Bit seven one means ready; bit six one means erase suspended.
// R13 - Host masks reserved status bits zero and one when polling.
// R14 - Program or erase is refused while a fail bit stands; clear-status first.
// R15 - The device sets a fail bit when its retry count exceeds the maximum.
// R16 - Sleep is three writes ending in its code; ignored once suspend was issued.
// R17 - Sleep finishes the running operation and keeps status bits.
// R18 - A sleeping device answers status reads; a write or read-array wakes it. The device model wakes only on read-array.
// R19 - Abort acts only during page program or chip or sector erase.
// R20 - Abort is three writes; it halts the operation and enters sleep.
// R21 - After an abort the program or erase fail bit is set.
// R22 - Power-up lands in read-array; memory changes only after full sequences.
// R23 - Under supply lockout the device ignores writes and returns to read mode.
// R24 - Erase-resume leaves suspension and clears bit six; otherwise no effect.
// R25 - Supply lockout arrives as one digital input from an external monitor.
//
// Our own choices: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/100ps
`include "flash_ctrl_regs.svh"

module flash_host_ctrl #(
	parameter int SETUP_CYC   = `SETUP_CYC,
	parameter int PULSE_CYC   = `PULSE_CYC,
	parameter int RECOVER_CYC = `RECOVER_CYC
) (
	input  wire logic                   ref_clk,
	input  wire logic                   rst,
	input  wire logic                   hsel,
	input  wire logic [31:0]            haddr,
	input  wire logic [1:0]             htrans,
	input  wire logic                   hwrite,
	input  wire logic [2:0]             hsize,
	input  wire logic [31:0]            hwdata,
	input  wire logic                   hready,
	output logic                        hreadyout,
	output logic                        hresp,
	output logic [31:0]                 hrdata,
	input  wire logic                   supply_lockout,
	input  wire logic [7:0]             dq_in,
	output flash_ctrl_pkg::flash_pins_t flash_pins
);
	import flash_ctrl_pkg::*;

	// --------------------
	// Declarations
	// --------------------
	typedef enum logic [1:0] {
		M_IDLE  = 2'b00,
		M_WRITE = 2'b01,
		M_READ  = 2'b11
	} main_state_t;

	main_state_t state_reg;
	op_t         op_reg;
	logic [2:0]  step_reg;
	logic [19:0] addr_reg;
	logic [7:0]  wdata_reg;
	logic [7:0]  array_reg;
	logic [7:0]  status_reg;
	logic        refused_reg;
	logic        suspended_reg;
	logic        failed_reg;
	logic        cyc_start_reg;
	bus_req_t    cyc_req_reg;
	logic        cyc_done;
	logic [7:0]  cyc_rdata;
	logic        wr_pend_reg;
	logic [7:0]  wr_addr_reg;
	logic        cmd_write;
	logic        cmd_ok;
	op_t         cmd_op;
	logic [2:0]  step_last;
	bus_req_t    step_now;
	logic [7:0]  status_masked;
	logic        is_status_op;

	// --------------------
	// Command sequence tables
	// --------------------

	// Number of write cycles an operation puts on the pins.
	function automatic logic [2:0] seq_len(op_t op);
		unique case (op)
			OP_PROGRAM, OP_SLEEP, OP_ABORT:  seq_len = 3'd3; // R16 R20
			OP_CHIP_ERASE, OP_SECT_ERASE:    seq_len = 3'd6;
			default:                         seq_len = 3'd1;
		endcase
	endfunction

	// Final command byte of each operation.
	function automatic logic [7:0] op_code(op_t op, logic [7:0] d);
		unique case (op)
			OP_READ_ARRAY:           op_code = `CODE_READ_ARRAY; // R02
			OP_READ_STATUS, OP_POLL: op_code = `CODE_READ_STATUS;
			OP_CLEAR:                op_code = `CODE_CLEAR;
			OP_PROGRAM:              op_code = `CODE_PROGRAM;
			OP_LOAD:                 op_code = d;
			OP_CHIP_ERASE:           op_code = `CODE_CHIP_ERASE;
			OP_SECT_ERASE:           op_code = `CODE_SECT_ERASE;
			OP_SLEEP:                op_code = `CODE_SLEEP; // R16
			OP_ABORT:                op_code = `CODE_ABORT; // R20
			OP_SUSPEND:              op_code = `CODE_SUSPEND;
			OP_RESUME:               op_code = `CODE_RESUME; // R24
			default:                 op_code = 8'h00;
		endcase
	endfunction

	// Address and data of one write step; unlock pairs precede each command byte of the three- and six-write sequences.
	function automatic bus_req_t step_req(op_t op, logic [2:0] idx, logic [19:0] a,
			logic [7:0] d);
		bus_req_t   r;
		logic [2:0] sub;
		sub    = (idx >= 3'd3) ? idx - 3'd3 : idx;
		r.wr   = 1'b1;
		r.addr = a;
		r.data = op_code(op, d);
		if (seq_len(op) != 3'd1) begin
			if (sub == 3'd0) begin
				r.addr = `UNLOCK1_ADDR;
				r.data = `UNLOCK1_DATA;
			end else if (sub == 3'd1) begin
				r.addr = `UNLOCK2_ADDR;
				r.data = `UNLOCK2_DATA;
			end else if (idx == 3'd2 && seq_len(op) == 3'd6) begin
				r.data = `CODE_ERASE_SETUP;
			end
		end
		step_req = r;
	endfunction

	// --------------------
	// Command decode
	// --------------------

	// A command write is taken only when idle and when the flash can act on it.
	always_comb begin
		cmd_write = wr_pend_reg && (wr_addr_reg == `OFS_CMD);
		cmd_op    = op_t'(hwdata[3:0]);
		cmd_ok    = (state_reg == M_IDLE) && (hwdata[3:0] <= 4'hb);
		if (supply_lockout)
			cmd_ok = 1'b0; // R23 R25
		if (failed_reg && (cmd_op == OP_PROGRAM || cmd_op == OP_LOAD ||
		    cmd_op == OP_CHIP_ERASE || cmd_op == OP_SECT_ERASE))
			cmd_ok = 1'b0; // R14
		if (suspended_reg && cmd_op == OP_SLEEP)
			cmd_ok = 1'b0; // R16
	end

	// Current step and the reserved-bit mask applied to every status byte.
	assign step_last     = seq_len(op_reg) - 3'd1;
	assign step_now      = step_req(op_reg, step_reg, addr_reg, wdata_reg);
	assign status_masked = cyc_rdata & `RESERVED_MASK; // R13 R03
	assign is_status_op  = (op_reg == OP_READ_STATUS) || (op_reg == OP_POLL);

	// --------------------
	// AHB-Lite slave
	// --------------------

	// Address phase is captured for the write that follows; no wait states.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
			hreadyout   <= 1'b1;
			hresp       <= 1'b0;
		end else begin
			wr_pend_reg <= hsel && htrans[1] && hready && hwrite && (hsize == 3'b010);
			wr_addr_reg <= haddr[7:0];
		end
	end

	// Read data is registered at the address phase and stands in the data phase.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			hrdata <= 32'h00000000;
		end else if (hsel && htrans[1] && hready && !hwrite) begin
			unique case (haddr[7:0])
				`OFS_CMD:    hrdata <= {28'h0000000, op_reg};
				`OFS_ADDR:   hrdata <= {12'h000, addr_reg};
				`OFS_WDATA:  hrdata <= {24'h000000, wdata_reg};
				`OFS_RDATA:  hrdata <= {24'h000000, array_reg};
				`OFS_STATUS: begin
					hrdata                <= {24'h000000, status_reg};
					hrdata[`ST_BUSY]      <= (state_reg != M_IDLE);
					hrdata[`ST_REFUSED]   <= refused_reg;
					hrdata[`ST_SUSPENDED] <= suspended_reg;
					hrdata[`ST_LOCKOUT]   <= supply_lockout;
					hrdata[`ST_FAILED]    <= failed_reg;
				end
				default:     hrdata <= 32'h00000000;
			endcase
		end
	end

	// Address and write data registers for the next operation.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			addr_reg  <= 20'h00000;
			wdata_reg <= 8'h00;
		end else if (wr_pend_reg) begin
			if (wr_addr_reg == `OFS_ADDR)
				addr_reg <= hwdata[19:0];
			if (wr_addr_reg == `OFS_WDATA)
				wdata_reg <= hwdata[7:0];
		end
	end

	// A refused command is remembered until the next command is taken.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			refused_reg <= 1'b0;
		else if (cmd_write)
			refused_reg <= !cmd_ok;
	end

	// --------------------
	// Operation sequencer
	// --------------------

	// Walks the write steps, then the reads; polling repeats until ready.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_reg     <= M_IDLE; // R22
			op_reg        <= OP_READ_ARRAY;
			step_reg      <= 3'd0;
			cyc_start_reg <= 1'b0;
			cyc_req_reg   <= '0;
		end else begin
			cyc_start_reg <= 1'b0;
			unique case (state_reg)
				M_IDLE: begin
					if (cmd_write && cmd_ok) begin
						op_reg        <= cmd_op;
						step_reg      <= 3'd0;
						cyc_req_reg   <= step_req(cmd_op, 3'd0, addr_reg, wdata_reg);
						cyc_start_reg <= 1'b1;
						state_reg     <= M_WRITE;
					end
				end
				M_WRITE: begin
					if (cyc_done) begin
						if (step_reg != step_last) begin
							step_reg      <= step_reg + 3'd1;
							cyc_req_reg   <= step_req(op_reg, step_reg + 3'd1, addr_reg,
								wdata_reg);
							cyc_start_reg <= 1'b1;
						end else if (is_status_op || op_reg == OP_READ_ARRAY) begin
							cyc_req_reg   <= '{wr: 1'b0, addr: addr_reg, data: 8'h00};
							cyc_start_reg <= 1'b1;
							state_reg     <= M_READ;
						end else begin
							state_reg <= M_IDLE;
						end
					end
				end
				M_READ: begin
					// Each poll is a separate cycle so output enable falls anew.
					if (cyc_done) begin
						if (op_reg == OP_POLL && !status_masked[`READY_BIT]) begin
							cyc_start_reg <= 1'b1; // R05 R01
						end else begin
							state_reg <= M_IDLE;
						end
					end
				end
				default: state_reg <= M_IDLE;
			endcase
		end
	end

	// Last array byte and last status byte, reserved bits held at zero.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			array_reg  <= 8'h00;
			status_reg <= 8'h00;
		end else if (state_reg == M_READ && cyc_done) begin
			if (is_status_op)
				status_reg <= status_masked; // R13
			else
				array_reg <= cyc_rdata;
		end
	end

	// Local fail flag: set by a failing status or an abort, cleared by clear-status.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			failed_reg <= 1'b0;
		end else if (state_reg == M_READ && cyc_done && is_status_op &&
		             (status_masked[`ERASE_FAIL_BIT] || status_masked[`PROGRAM_FAIL_BIT])) begin
			failed_reg <= 1'b1; // R07
		end else if (state_reg == M_WRITE && cyc_done && step_reg == step_last) begin
			if (op_reg == OP_ABORT)
				failed_reg <= 1'b1; // R21
			else if (op_reg == OP_CLEAR)
				failed_reg <= 1'b0; // R14
		end
	end

	// Suspend issued blocks sleep until resume or abort.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			suspended_reg <= 1'b0;
		end else if (state_reg == M_WRITE && cyc_done && step_reg == step_last) begin
			if (op_reg == OP_SUSPEND)
				suspended_reg <= 1'b1; // R16
			else if (op_reg == OP_RESUME || op_reg == OP_ABORT)
				suspended_reg <= 1'b0; // R24
		end
	end

	// --------------------
	// Pin cycle generator
	// --------------------
	flash_bus_cycle #(
		.SETUP_CYC   (SETUP_CYC),
		.PULSE_CYC   (PULSE_CYC),
		.RECOVER_CYC (RECOVER_CYC)
	) u_cycle (
		.ref_clk (ref_clk),
		.rst     (rst),
		.start   (cyc_start_reg),
		.req     (cyc_req_reg),
		.dq_in   (dq_in),
		.pins    (flash_pins),
		.done    (cyc_done),
		.rdata   (cyc_rdata)
	);

endmodule

// ### verification/flash_dev_model.sv
// Behavioural flash device answering the controller's strobe cycles.
`timescale 1ns/100ps
module flash_dev_model #(
	parameter int   PROG_NS  = 400,
	parameter int   ERASE_NS = 3000,
	parameter logic PROTECT  = 1'b0
) (
	input  wire logic        ce_n,
	input  wire logic        we_n,
	input  wire logic        oe_n,
	input  wire logic [19:0] addr,
	input  wire logic [7:0]  dq,
	input  wire logic        supply_lockout,
	input  wire logic        inject_fail,
	output logic      [7:0]  dq_drv
);
	// All state powers up cleared: read-array mode, ready, no fail, no sleep.
	logic [7:0] mem [int];
	bit stat_mode, susp, susp_done, efail, pfail, sleep, busy, erasing, loading;
	int seq, op_id;

	initial dq_drv = 8'h00;

	// Builds the status byte; the low two bits always read zero.
	function automatic logic [7:0] st_byte();
		return {!busy || susp_done, susp, efail, pfail, PROTECT, sleep, 2'b00};
	endfunction

	// Runs one program or erase; a newer op id cancels the pending finish.
	task automatic start_op(input int ns, input bit er);
		int id;
		op_id++;
		id = op_id;
		busy = 1;
		erasing = er;
		stat_mode = 1;
		fork
			begin
				#(ns);
				if (id == op_id) begin
					busy = 0;
					if (inject_fail) efail = er;
					if (inject_fail) pfail = !er;
				end
			end
		join_none
	endtask

	// Decodes one write; unlock pairs lead to the three- and six-write codes.
	task automatic wr(input logic [19:0] a, input logic [7:0] d);
		int s;
		s = seq;
		if (loading) begin
			loading = 0;
			mem[a] = d;
			start_op(PROG_NS, 0);
		end else if ((s == 0 || s == 3) && a == 20'h05555 && d == 8'haa) begin
			seq++;
		end else if ((s == 1 || s == 4) && a == 20'h02aaa && d == 8'h55) begin
			seq++;
		end else begin
			seq = (s == 2 && d == 8'h80) ? 3 : 0;
			if (s == 2 && d == 8'ha0 && !pfail && !efail) loading = 1;
			if (s == 5 && (d == 8'h10 || d == 8'h30) && !pfail && !efail) start_op(ERASE_NS, 1);
			if (s == 2 && d == 8'hc0 && !susp) begin
				sleep = 1;
				stat_mode = 1;
			end
			if (s == 2 && d == 8'he0 && busy) begin
				op_id++;
				busy = 0;
				susp = 0;
				susp_done = 0;
				sleep = 1;
				stat_mode = 1;
				efail = efail || erasing;
				pfail = pfail || !erasing;
			end
			if (s == 0 && d == 8'hff) begin
				stat_mode = 0;
				sleep = 0;
			end
			if (s == 0 && d == 8'h70) stat_mode = 1;
			if (s == 0 && d == 8'h50) begin
				efail = 0;
				pfail = 0;
			end
			if (s == 0 && d == 8'hb0 && busy && erasing && !susp) begin
				susp = 1;
				op_id++;
				fork
					#50 susp_done = 1;
				join_none
			end
			if (s == 0 && d == 8'hd0 && susp) begin
				susp = 0;
				susp_done = 0;
				start_op(ERASE_NS, 1);
			end
		end
	endtask

	// Low supply drops to read mode and cancels any program or erase.
	always @(posedge supply_lockout) begin
		stat_mode = 0;
		op_id++;
		busy = 0;
		seq = 0;
		loading = 0;
	end

	// Writes are taken at the rising write strobe and ignored under lockout.
	always @(posedge we_n) if (!ce_n && !supply_lockout) wr(addr, dq);

	// Read data is latched at the later falling enable, also while asleep.
	always @(negedge oe_n or negedge ce_n)
		if (!oe_n && !ce_n) dq_drv = stat_mode ? st_byte() : (mem.exists(addr) ? mem[addr] : 8'hff);
	// A released bus shows the inverse of the last value, never a held copy.
	always @(posedge oe_n) dq_drv = ~dq_drv;
endmodule

// ### verification/flash_host_ctrl_asserts.sv
// Concurrent checks on the flash host controller's bus and flash pin ports.
`timescale 1ns/100ps
module flash_host_ctrl_asserts #(
	parameter int SETUP_CYC   = 2,
	parameter int PULSE_CYC   = 5,
	parameter int RECOVER_CYC = 3
) (
	input wire logic                   ref_clk,
	input wire logic                   rst,
	input wire logic                   hsel,
	input wire logic [31:0]            haddr,
	input wire logic [1:0]             htrans,
	input wire logic                   hwrite,
	input wire logic                   hreadyout,
	input wire logic                   hresp,
	input wire logic [31:0]            hrdata,
	input flash_ctrl_pkg::flash_pins_t flash_pins
);
	import flash_ctrl_pkg::*;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	// --------------------
	// Helper state
	// --------------------
	logic rd_stat;
	int   low_cnt;

	// Marks the data phase of a read of the status word.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rd_stat <= 1'b0;
		end else begin
			rd_stat <= hsel && htrans[1] && !hwrite && (haddr == 32'h10);
		end
	end

	// Counts the cycles for which a read or write strobe is low.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			low_cnt <= 0;
		end else if (!flash_pins.we_n || !flash_pins.oe_n) begin
			low_cnt <= low_cnt + 1;
		end else begin
			low_cnt <= 0;
		end
	end

	// --------------------
	// Assertions
	// --------------------
	a_bus_always_okay: assert property (hreadyout && !hresp)
		else $error("bus slave not ready or not okay");
	a_strobe_needs_ce: assert property ((!flash_pins.we_n || !flash_pins.oe_n) |-> !flash_pins.ce_n)
		else $error("strobe low without chip enable");
	a_no_rw_overlap: assert property (flash_pins.we_n || flash_pins.oe_n)
		else $error("read and write strobes low together");
	a_oe_no_drive: assert property (!flash_pins.oe_n |-> !flash_pins.dq_oe)
		else $error("controller drives data during a read");
	a_addr_stable: assert property ((!flash_pins.ce_n && !$past(flash_pins.ce_n)) |-> $stable(flash_pins.addr))
		else $error("address moved inside a cycle");
	a_pulse_width: assert property ((flash_pins.we_n && flash_pins.oe_n && low_cnt != 0) |-> low_cnt == PULSE_CYC)
		else $error("strobe pulse width wrong");
	a_oe_toggle: assert property ($rose(flash_pins.oe_n) |=> flash_pins.oe_n ##1 flash_pins.oe_n)
		else $error("output enable not toggled between reads");
	a_status_low_zero: assert property (rd_stat |-> (hrdata[1:0] == 2'b00) && (hrdata[31:13] == 19'h0))
		else $error("status word reserved bits not zero");
endmodule

bind flash_host_ctrl flash_host_ctrl_asserts #(
	.SETUP_CYC(SETUP_CYC), .PULSE_CYC(PULSE_CYC), .RECOVER_CYC(RECOVER_CYC)
) chk_u (
	.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
	.flash_pins(flash_pins)
);

// ### verification/tb_top.sv
// Self-checking bench for the flash host controller with a behavioural flash.
`timescale 1ns/100ps
module tb_top;
	import flash_ctrl_pkg::*;
	logic        ref_clk, rst, hsel, hwrite, hreadyout, hresp, supply_lockout, inject_fail;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [7:0]  dev_dq, dq_bus, wv;
	logic [19:0] av;
	flash_pins_t flash_pins;
	int          n_mismatch, checked, cyc;

	// Data wire: the controller drives it on writes, the device otherwise.
	assign dq_bus = flash_pins.dq_oe ? flash_pins.dq_out : dev_dq;

	flash_host_ctrl #(.SETUP_CYC(1), .PULSE_CYC(1), .RECOVER_CYC(1)) dut_u (
		.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.supply_lockout(supply_lockout), .dq_in(dq_bus), .flash_pins(flash_pins));
	flash_dev_model dev_u (
		.ce_n(flash_pins.ce_n), .we_n(flash_pins.we_n), .oe_n(flash_pins.oe_n),
		.addr(flash_pins.addr), .dq(dq_bus), .supply_lockout(supply_lockout),
		.inject_fail(inject_fail), .dq_drv(dev_dq));

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// Prints the counts and the verdict, then ends the run.
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Cuts a hang short after a generous number of cycles.
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 30000) begin
			n_mismatch++;
			close_out();
		end
	end

	// One single AHB-Lite word transfer; read data lands in rd.
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= d;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Issues one operation and waits until the controller is idle again.
	task automatic op(input logic [3:0] c);
		ahb(1'b1, 8'h00, {28'h0, c});
		do ahb(1'b0, 8'h10, 32'h0); while (rd[8] !== 1'b0);
	endtask

	// Reference status byte worked out from the status bit meanings.
	function automatic logic [7:0] es(int s, int e, int p, int sl);
		return {1'b1, s[0], e[0], p[0], 1'b0, sl[0], 2'b00};
	endfunction

	// Compares the last flash status byte with the reserved bits masked.
	task automatic st_chk(input logic [7:0] e);
		ahb(1'b0, 8'h10, 32'h0);
		chk("flash status", {24'h0, e}, {24'h0, rd[7:0] & 8'hfc});
	endtask

	initial begin
		rst = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0;
		supply_lockout = 1'b0;
		inject_fail = 1'b0;
		void'($urandom(47));
		repeat (12) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		op(OP_POLL);
		st_chk(es(0, 0, 0, 0));
		av = $urandom;
		wv = $urandom;
		ahb(1'b1, 8'h04, {12'h0, av});
		ahb(1'b1, 8'h08, {24'h0, wv});
		op(OP_PROGRAM);
		op(OP_LOAD);
		op(OP_POLL);
		st_chk(es(0, 0, 0, 0));
		op(OP_READ_ARRAY);
		ahb(1'b0, 8'h0c, 32'h0);
		chk("array byte", {24'h0, wv}, rd);
		$display("test program done");
		inject_fail <= 1'b1;
		op(OP_PROGRAM);
		op(OP_LOAD);
		op(OP_POLL);
		inject_fail <= 1'b0;
		st_chk(es(0, 0, 1, 0));
		op(OP_SECT_ERASE);
		chk("erase refused", 32'h3, {30'h0, rd[12], rd[9]});
		op(OP_POLL);
		st_chk(es(0, 0, 1, 0));
		op(OP_CLEAR);
		op(OP_POLL);
		st_chk(es(0, 0, 0, 0));
		$display("test fail done");
		op(OP_PROGRAM);
		op(OP_LOAD);
		op(OP_SLEEP);
		op(OP_POLL);
		st_chk(es(0, 0, 0, 1));
		op(OP_READ_ARRAY);
		op(OP_POLL);
		st_chk(es(0, 0, 0, 0));
		$display("test sleep done");
		op(OP_CHIP_ERASE);
		op(OP_ABORT);
		op(OP_POLL);
		st_chk(es(0, 1, 0, 1));
		op(OP_CLEAR);
		op(OP_READ_ARRAY);
		op(OP_ABORT);
		op(OP_POLL);
		st_chk(es(0, 0, 0, 0));
		op(OP_CLEAR);
		$display("test abort done");
		op(OP_SECT_ERASE);
		op(OP_SUSPEND);
		op(OP_POLL);
		st_chk(es(1, 0, 0, 0));
		op(OP_SLEEP);
		chk("sleep refused", 32'h3, {30'h0, rd[10], rd[9]});
		op(OP_RESUME);
		op(OP_POLL);
		st_chk(es(0, 0, 0, 0));
		$display("test suspend done");
		supply_lockout <= 1'b1;
		op(OP_READ_STATUS);
		chk("lockout refused", 32'h3, {30'h0, rd[11], rd[9]});
		supply_lockout <= 1'b0;
		ahb(1'b0, 8'h14, 32'h0);
		chk("unmapped read", 32'h0, rd);
		op(4'hc);
		chk("bad op refused", 32'h1, {31'h0, rd[9]});
		$display("test refusal done");
		close_out();
	end
endmodule
